// file: common/adc_ctrl_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz sys_clk, Avalon-MM byte addresses, one word per register
// Notes: Included by its bare name
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

`define OFS_MODE 5'h00
`define OFS_CHAN 5'h04
`define OFS_PIN 5'h08
`define OFS_RESULT 5'h0c
`define OFS_RESULT_HI 5'h10
`define OFS_IRQ_STAT 5'h14
`define OFS_IRQ_MASK 5'h18
`define OFS_STATUS 5'h1c

`define MODE_START_BIT 7
`define MODE_CMP_EN_BIT 0
`define MODE_TIME_LSB 1
`define MODE_TIME_MSB 5
`define CHAN_W 2
`define PIN_W 3
`define RESULT_W 10

`define MODE_RST 8'h00
`define CHAN_RST 2'h0
`define PIN_RST 3'h0
`define MASK_RST 2'h0

`define IRQ_END_BIT 0
`define IRQ_DROP_BIT 1

`define CLK_MHZ 10
`define START_GAP_NS 1000
`define START_GAP_CYC ((`START_GAP_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: common/adc_ctrl_pkg.sv
// Purpose: Types shared by the converter control logic
// Assumes: Nothing beyond the defs header
// Notes: Sequencer state codes are written out
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } seq_state_t;
endpackage : adc_ctrl_pkg

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the converter sequencing control block
// Assumes: Bench acts as Avalon-MM master; comparator input set per scenario
// Notes: Cycle counts follow the hand-over timing of the design
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
`default_nettype none

module tb_top;
  localparam int SMP = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stop_mode = 1'b0;
  logic comparator_in = 1'b1;
  logic [9:0] dac_code;
  logic sample_hold;
  logic comparator_enable_bit;
  logic [1:0] channel_select;
  logic [2:0] analog_pin_config;
  logic conversion_end_interrupt;
  logic irq;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  int cyc;

  always #50 sys_clk = ~sys_clk;

  adc_sequencing_control #(.SETTLE_STEPS(2), .SAMPLE_STEPS(SMP))
    u_adc_sequencing_control (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stop_mode(stop_mode), .comparator_in(comparator_in),
    .dac_code(dac_code), .sample_hold(sample_hold),
    .comparator_enable_bit(comparator_enable_bit),
    .channel_select(channel_select),
    .analog_pin_config(analog_pin_config),
    .conversion_end_interrupt(conversion_end_interrupt), .irq(irq));

  task finish_test;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer; cyc counts edges from raise to accept
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      finish_test;
    end
    rd = avs_readdata;
    cyc = n;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rdchk(input logic [4:0] a, input logic [31:0] exp, input int ec);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(cyc), 32'(ec));
  endtask : rdchk

  task wait_end(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (conversion_end_interrupt !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      n_errors++;
      finish_test;
    end
  endtask : wait_end

  task wait_sample;
    int n;
    for (n = 0; n < 500 && sample_hold !== 1'b1; n++) begin
      @(posedge sys_clk);
    end
    if (sample_hold !== 1'b1) begin
      n_errors++;
      finish_test;
    end
  endtask : wait_sample

  task t_reset;
    rdchk(`OFS_MODE, 32'h0, 2);
    rdchk(`OFS_CHAN, 32'h0, 2);
    rdchk(`OFS_PIN, 32'h0, 2);
    rdchk(`OFS_IRQ_MASK, 32'h0, 2);
    rdchk(5'h01, 32'h0, 2);
    rdchk(`OFS_RESULT, 32'h0, 3);
    rdchk(`OFS_RESULT_HI, 32'h0, 3);
  endtask : t_reset

  // Only legal low bits written, upper bits stay zero
  // Port direction of the chosen channel lies outside this block
  task t_regs;
    bus(1'b1, `OFS_CHAN, 32'h3);
    chk(32'(cyc), 32'h3);
    @(posedge sys_clk);
    chk(32'(channel_select), 32'h3);
    bus(1'b1, `OFS_PIN, 32'h5);
    chk(32'(cyc), 32'h3);
    @(posedge sys_clk);
    chk(32'(analog_pin_config), 32'h5);
    rdchk(`OFS_CHAN, 32'h3, 2);
    rdchk(`OFS_PIN, 32'h5, 2);
    bus(1'b1, `OFS_CHAN, 32'h0);
    bus(1'b1, `OFS_PIN, 32'h0);
  endtask : t_regs

  // Step one first, start only once the comparator is warm
  // Step one may sit anywhere in steps two to four; here it leads
  // Step one is never skipped, so no first result is dropped
  task start_conv(input logic [7:0] m);
    int k;
    k = 0;
    bus(1'b1, `OFS_MODE, {24'h0, m & 8'h7f});
    do begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 20);
    chk(32'(rd[1]), 32'h1);
    chk(32'(k), 32'h4);
    bus(1'b1, `OFS_MODE, {24'h0, m});
  endtask : start_conv

  // Result is read before any config write, as software must
  task t_conv(input logic [4:0] t, input logic cmp);
    int n;
    comparator_in <= cmp;
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    chk(32'(cyc), 32'h2);
    start_conv({1'b1, 1'b0, t, 1'b1});
    wait_sample;
    chk(32'(comparator_enable_bit), 32'h1);
    wait_end(n);
    chk(32'(n), 32'((SMP + 10) * (t + 1)));
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    rdchk(`OFS_RESULT, {22'h0, {10{cmp}}}, 3);
    rdchk(`OFS_RESULT_HI, {24'h0, {8{cmp}}}, 3);
    bus(1'b1, `OFS_MODE, 32'h0);
    rdchk(`OFS_IRQ_STAT, 32'h1, 2);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    rdchk(`OFS_IRQ_STAT, 32'h0, 2);
  endtask : t_conv

  task t_stop;
    int n;
    int pulses;
    pulses = 0;
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    start_conv(8'h81);
    wait_sample;
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(sample_hold), 32'h0);
    chk(32'(dac_code), 32'h0);
    repeat (300) begin
      @(posedge sys_clk);
      pulses += int'(conversion_end_interrupt === 1'b1);
    end
    chk(32'(pulses), 32'h0);
    stop_mode <= 1'b0;
    wait_end(n);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, `OFS_MODE, 32'h0);
    rdchk(`OFS_IRQ_STAT, 32'h1, 2);
  endtask : t_stop

  // Conversion end meets a result read, then a config write
  task t_clash;
    int n;
    int k;
    comparator_in <= 1'b1;
    start_conv(8'h83);
    wait_end(n);
    comparator_in <= 1'b0;
    // Seventh read is in flight at the next end, so its store waits
    for (k = 0; k < 8; k++) begin
      rdchk(`OFS_RESULT, (k < 7) ? 32'h3ff : 32'h0, 3);
    end
    bus(1'b1, `OFS_MODE, 32'h0);
    rdchk(`OFS_IRQ_STAT, 32'h1, 2);
    comparator_in <= 1'b1;
    start_conv(8'h83);
    wait_end(n);
    comparator_in <= 1'b0;
    rdchk(`OFS_IRQ_STAT, 32'h1, 2);
    // Channel write accepted on the very edge of the next end
    repeat (20) @(posedge sys_clk);
    bus(1'b1, `OFS_CHAN, 32'h0);
    @(posedge sys_clk);
    chk(32'(conversion_end_interrupt), 32'h0);
    bus(1'b1, `OFS_MODE, 32'h0);
    rdchk(`OFS_RESULT, 32'h3ff, 3);
    rdchk(`OFS_IRQ_STAT, 32'h2, 2);
  endtask : t_clash

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_regs;
    t_conv(5'h01, 1'b1);
    t_conv(5'h03, 1'b0);
    t_stop;
    t_clash;
    finish_test;
  end
endmodule : tb_top

`default_nettype wire

// file: verilog/adc_sequencing_control.sv
// Purpose: Register, wait and sequencing control of a 10-bit SAR converter
// Assumes: Comparator output is asynchronous; stop_mode is on sys_clk
// Notes: Software reaches the registers over Avalon-MM with waitrequest
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
`default_nettype none

module adc_sequencing_control
  import adc_ctrl_pkg::*;
#(
  parameter int SETTLE_STEPS = 2,
  parameter int SAMPLE_STEPS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stop_mode,
  input wire logic comparator_in,
  output logic [9:0] dac_code,
  output logic sample_hold,
  output logic comparator_enable_bit,
  output logic [1:0] channel_select,
  output logic [2:0] analog_pin_config,
  output logic conversion_end_interrupt,
  output logic irq
);

  localparam int N_STEPS = SAMPLE_STEPS + `RESULT_W;

  function automatic logic is_result(input logic [4:0] a);
    is_result = (a == `OFS_RESULT) || (a == `OFS_RESULT_HI);
  endfunction : is_result

  function automatic logic is_cfg(input logic [4:0] a);
    is_cfg = (a == `OFS_MODE) || (a == `OFS_CHAN) || (a == `OFS_PIN);
  endfunction : is_cfg

  function automatic logic [9:0] onehot(input logic [3:0] b);
    onehot = 10'h001 << b;
  endfunction : onehot

  logic [7:0] converter_mode_q;
  logic [1:0] channel_select_q;
  logic [2:0] pin_config_q;
  logic [9:0] result_q, pend_data_q, sar_q, sar_d, res_new, dac_q;
  logic pend_q, wait_q, wcnt_q, cmp_meta_q, cmp_s_q, end_q, irq_q, sh_q;
  logic [1:0] stat_q, mask_q, stat_set, stat_clr;
  logic [31:0] rdata_q;
  logic [5:0] div_q;
  logic [3:0] step_q, step_d, bit_q, bit_d;
  logic [7:0] gap_q;
  seq_state_t state_q, state_d;
  logic eoc;

  wire req = avs_read | avs_write;
  wire need_wait = (avs_read & is_result(avs_address)) |
                   (avs_write & is_cfg(avs_address));
  wire acc = req & ~wait_q;
  wire wr_acc = acc & avs_write & avs_byteenable[0];
  wire wr_cfg_acc = wr_acc & is_cfg(avs_address);
  wire rd_stat_acc = acc & avs_read & (avs_address == `OFS_IRQ_STAT);
  wire rd_res_pend = avs_read & is_result(avs_address);
  wire conv_start = converter_mode_q[`MODE_START_BIT];
  wire [5:0] step_m1 = {1'b0, converter_mode_q[`MODE_TIME_MSB:`MODE_TIME_LSB]};
  wire tick = (div_q >= step_m1);
  wire eoc_ok = eoc & ~wr_cfg_acc & ~stop_mode;
  wire warm = (gap_q >= 8'(`START_GAP_CYC));
  wire busy = (state_q != ST_IDLE);
  wire [31:0] rd_mux =
    (avs_address == `OFS_MODE) ? {24'h0, converter_mode_q} :
    (avs_address == `OFS_CHAN) ? {30'h0, channel_select_q} :
    (avs_address == `OFS_PIN) ? {29'h0, pin_config_q} :
    (avs_address == `OFS_RESULT) ? {22'h0, result_q} :
    (avs_address == `OFS_RESULT_HI) ? {24'h0, result_q[9:2]} :
    (avs_address == `OFS_IRQ_STAT) ? {30'h0, stat_q} :
    (avs_address == `OFS_IRQ_MASK) ? {30'h0, mask_q} :
    (avs_address == `OFS_STATUS) ? {30'h0, warm, busy} : 32'h0;

  assign stat_set = {eoc & wr_cfg_acc, eoc_ok};
  assign stat_clr = rd_stat_acc ? 2'h3 : 2'h0;

  // Bus handshake: one wait state always, one more on waited accesses
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      wcnt_q <= 1'b0;
      rdata_q <= 32'h0;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (req && (wcnt_q == need_wait)) begin
      wait_q <= 1'b0;
      wcnt_q <= 1'b0;
      rdata_q <= rd_mux;
    end else if (req) begin
      wcnt_q <= 1'b1;
    end
  end

  // Upper bits are not stored, so they read back as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      converter_mode_q <= `MODE_RST;
      channel_select_q <= `CHAN_RST;
      pin_config_q <= `PIN_RST;
      mask_q <= `MASK_RST;
    end else if (wr_acc) begin
      if (avs_address == `OFS_MODE)
        converter_mode_q <= avs_writedata[7:0];
      if (avs_address == `OFS_CHAN)
        channel_select_q <= avs_writedata[`CHAN_W-1:0];
      if (avs_address == `OFS_PIN)
        pin_config_q <= avs_writedata[`PIN_W-1:0];
      if (avs_address == `OFS_IRQ_MASK)
        mask_q <= avs_writedata[1:0];
    end
  end

  // Set wins over the read-clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq_q <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
    end
  end

  // Comparator settling time seen by software as the warm flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      gap_q <= 8'h00;
    else if (!converter_mode_q[`MODE_CMP_EN_BIT])
      gap_q <= 8'h00;
    else if (!warm)
      gap_q <= gap_q + 8'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmp_meta_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end else begin
      cmp_meta_q <= comparator_in;
      cmp_s_q <= cmp_meta_q;
    end
  end

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    bit_d = bit_q;
    sar_d = sar_q;
    res_new = sar_q;
    eoc = 1'b0;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_SETTLE;
        step_d = 4'h0;
      end
      ST_SETTLE: begin
        if (tick && (step_q == 4'(SETTLE_STEPS - 1))) begin
          state_d = ST_SAMPLE;
          step_d = 4'h0;
        end else if (tick) begin
          step_d = step_q + 4'h1;
        end
      end
      ST_SAMPLE: begin
        if (tick && (step_q == 4'(SAMPLE_STEPS - 1))) begin
          state_d = ST_CONVERT;
          bit_d = 4'h9;
          sar_d = 10'h000;
        end else if (tick) begin
          step_d = step_q + 4'h1;
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          sar_d = sar_q | (cmp_s_q ? onehot(bit_q) : 10'h000);
          if (bit_q == 4'h0) begin
            eoc = 1'b1;
            res_new = sar_d;
            state_d = ST_SAMPLE;
            step_d = 4'h0;
          end else begin
            bit_d = bit_q - 4'h1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Config writes restart the sequence; stop halts it
    if (stop_mode || !conv_start || wr_cfg_acc)
      state_d = ST_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
      bit_q <= 4'h0;
      sar_q <= 10'h000;
      div_q <= 6'h00;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
      div_q <= (state_q == ST_IDLE || tick) ? 6'h00 : div_q + 6'h01;
    end
  end

  // A pending result waits out a result read in flight
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_q <= 10'h000;
      pend_q <= 1'b0;
      pend_data_q <= 10'h000;
    end else if (eoc_ok && rd_res_pend) begin
      pend_q <= 1'b1;
      pend_data_q <= res_new;
    end else if (eoc_ok) begin
      result_q <= res_new;
      pend_q <= 1'b0;
    end else if (pend_q && !rd_res_pend) begin
      result_q <= pend_data_q;
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      end_q <= 1'b0;
      dac_q <= 10'h000;
      sh_q <= 1'b0;
    end else begin
      end_q <= eoc_ok;
      dac_q <= (state_d == ST_CONVERT) ? (sar_d | onehot(bit_d)) : 10'h000;
      sh_q <= (state_d == ST_SAMPLE);
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign dac_code = dac_q;
  assign sample_hold = sh_q;
  assign comparator_enable_bit = converter_mode_q[`MODE_CMP_EN_BIT];
  assign channel_select = channel_select_q;
  assign analog_pin_config = pin_config_q;
  assign conversion_end_interrupt = end_q;
  assign irq = irq_q;

  // Cycles since the sample phase began
  logic [15:0] conv_cyc_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      conv_cyc_q <= 16'h0000;
    else if (state_d == ST_SAMPLE && state_q != ST_SAMPLE)
      conv_cyc_q <= 16'h0001;
    else
      conv_cyc_q <= conv_cyc_q + 16'h0001;
  end

  result_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc && avs_read && is_result(avs_address) |->
      $past(req && wait_q, 1) && $past(req && wait_q, 2))
    else $error("Result read without wait cycle");

  chan_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc && avs_write && avs_address == `OFS_CHAN |->
      $past(req && wait_q, 1) && $past(req && wait_q, 2))
    else $error("Channel write without wait cycle");

  pin_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc && avs_write && avs_address == `OFS_PIN |->
      $past(req && wait_q, 1) && $past(req && wait_q, 2))
    else $error("Pin config write without wait cycle");

  conv_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eoc |-> conv_cyc_q == 16'(N_STEPS * (int'(step_m1) + 1)))
    else $error("Conversion time mismatch");

  read_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_res_pend |=> $stable(result_q))
    else $error("Result changed during result read");

  write_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eoc && wr_cfg_acc && !pend_q |=> $stable(result_q) && !end_q)
    else $error("Result stored despite config write");

  stop_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_mode |=> state_q == ST_IDLE && !sh_q)
    else $error("Converter running in stop mode");

  cfg_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_cfg_acc |=> state_q == ST_IDLE)
    else $error("Config write did not restart sequence");

  start_seq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_IDLE && conv_start && !stop_mode && !wr_cfg_acc
      |=> state_q == ST_SETTLE)
    else $error("Start bit did not begin sequence");

endmodule : adc_sequencing_control

`default_nettype wire
